/* File: rtl/lsu_cfg.svh */
// Constants of the load-store unit: widths, depths, register offsets and fields
`ifndef LSU_CFG_SVH
`define LSU_CFG_SVH
`define LSU_DW 32
`define LSU_AW 32
`define LSU_BEW 4
`define LSU_BCW 8
`define LSU_MAXBURST 8
`define LSU_OQ_DEPTH 8
`define LSU_REG_CTRL 8'h00
`define LSU_REG_STATUS 8'h04
`define LSU_CTRL_STYLE_LSB 0
`define LSU_CTRL_MAXB_LSB 8
`define LSU_STAT_BUSY_BIT 0
`define LSU_STAT_OUT_LSB 8
`define LSU_STAT_BUF_LSB 16
`endif

/* File: rtl/lsu_pkg.sv */
// Types shared by the load-store unit
package lsu_pkg;
`include "lsu_cfg.svh"

  // Unit style as software selects it
  typedef enum logic [1:0] {
    STYLE_BURST = 2'h0,
    STYLE_NONALIGNED = 2'h1,
    STYLE_PIPELINED = 2'h2,
    STYLE_NEVERSTALL = 2'h3
  } lsu_style_e;

  // Burst engine states, one-hot
  typedef enum logic [2:0] {
    ST_COLLECT = 3'b001,
    ST_WRBURST = 3'b010,
    ST_RDBURST = 3'b100
  } lsu_state_e;

  // Request from the datapath, lanes already merged into one word
  typedef struct packed {
    logic write;
    logic [`LSU_AW-1:0] addr;
    logic [`LSU_DW-1:0] data;
    logic [`LSU_BEW-1:0] be;
  } lsu_req_s;

  // Command on the memory master port
  typedef struct packed {
    logic read;
    logic write;
    logic [`LSU_AW-1:0] addr;
    logic [`LSU_BCW-1:0] burst;
    logic [`LSU_DW-1:0] wdata;
    logic [`LSU_BEW-1:0] be;
  } lsu_mem_cmd_s;

  // One pending load in return order
  typedef struct packed {
    logic split;
    logic [1:0] off;
  } lsu_ord_s;
endpackage : lsu_pkg

/* File: rtl/lsu_mem_master_port.sv */
// Load-store unit between the datapath and the memory master port
`timescale 1ns/100ps
`include "lsu_cfg.svh"

// Functional notes
// - Default style follows latency kind of port
// - Buffer contiguous requests, burst at maximum length or when a cycle adds no word
// - Noncontiguous request flushes buffered burst first
// - Nonaligned variant for possibly misaligned elements
// - Spanning element touches both words, still coalesced
// - Pipelined style forwards each request at once
// - Pipelined style never forms bursts
// - Pipelined style keeps several loads outstanding
// - Never-stall style ignores waitrequest, loads still wait for room in the order queue
// - Consecutive lanes merged into one wide access
// - Merged access never wider than port
// - Maximum burst length bounds transfers per command
module lsu_mem_master_port
  import lsu_pkg::*;
#(
  parameter int MAXB = `LSU_MAXBURST, // Deepest burst buffer
  parameter int OQD = `LSU_OQ_DEPTH, // Most loads in flight
  parameter bit VARIABLE_LATENCY = 1'b1, // Port has variable latency
  parameter bit NEVER_STALL_TARGET = 1'b0 // On-chip or unarbitrated fixed latency
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire lsu_req_s req,
  input wire logic reqValid,
  output logic reqReady,
  output logic [`LSU_DW-1:0] rspData,
  output logic rspValid,
  output lsu_mem_cmd_s memCmd,
  input wire logic memWaitRequest,
  input wire logic memReadDataValid,
  input wire logic [`LSU_DW-1:0] memReadData
);

  localparam int DW = `LSU_DW;
  localparam int AW = `LSU_AW;
  localparam int BEW = `LSU_BEW;
  localparam int CW = $clog2(MAXB + 1);
  localparam int IW = (MAXB > 1) ? $clog2(MAXB) : 1;
  localparam int QW = (OQD > 1) ? $clog2(OQD) : 1;
  localparam int NW = $clog2(OQD + 1);
  localparam int OFFW = $clog2(BEW);
  localparam lsu_style_e STYLE_RST = VARIABLE_LATENCY ? STYLE_BURST :
    (NEVER_STALL_TARGET ? STYLE_NEVERSTALL : STYLE_PIPELINED);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus slave

  logic aValid; // Data phase pending
  logic aWrite; // Pending phase is a write
  logic [7:0] aAddr; // Pending word offset
  lsu_style_e cfgStyle; // Selected style
  logic [7:0] cfgMaxb; // Burst limit, zero means largest
  logic [31:0] next_hrdata;
  logic next_aValid;
  logic next_aWrite;
  logic [7:0] next_aAddr;
  lsu_style_e next_cfgStyle;
  logic [7:0] next_cfgMaxb;
  logic [31:0] statusWord; // Live state for software

  lsu_state_e state; // Burst engine state
  logic [CW-1:0] bufCnt; // Words held in the buffer
  logic pValid; // Pipelined command slot occupied
  logic [NW-1:0] oqCnt; // Loads in flight

  // Busy, loads in flight and buffered words
  always_comb
  begin
    statusWord = 32'h0;
    statusWord[`LSU_STAT_BUSY_BIT] = (state != ST_COLLECT) || (bufCnt != '0) || pValid || (oqCnt != '0);
    statusWord[`LSU_STAT_OUT_LSB +: 8] = 8'(oqCnt);
    statusWord[`LSU_STAT_BUF_LSB +: 8] = 8'(bufCnt);
  end

  // Address phase capture, read data and control writes
  always_comb
  begin
    next_aValid = hsel && htrans[1] && hready;
    next_aWrite = hwrite;
    next_aAddr = {haddr[7:2], 2'b00};
    next_hrdata = hrdata;
    next_cfgStyle = cfgStyle;
    next_cfgMaxb = cfgMaxb;
    // Data phase of a write updates control
    if (aValid && aWrite && (aAddr == `LSU_REG_CTRL))
    begin
      next_cfgStyle = lsu_style_e'(hwdata[`LSU_CTRL_STYLE_LSB +: 2]);
      next_cfgMaxb = hwdata[`LSU_CTRL_MAXB_LSB +: 8];
    end
    // Read data prepared for the coming data phase
    if (next_aValid && !hwrite)
    begin
      case (next_aAddr)
        `LSU_REG_CTRL: next_hrdata = {16'h0, cfgMaxb, 6'h0, cfgStyle};
        `LSU_REG_STATUS: next_hrdata = statusWord;
        default: next_hrdata = 32'h0;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      aValid <= 1'b0;
      aWrite <= 1'b0;
      aAddr <= 8'h00;
      hrdata <= 32'h0;
      cfgStyle <= STYLE_RST;
      cfgMaxb <= 8'h00;
    end
    else
    begin
      aValid <= next_aValid;
      aWrite <= next_aWrite;
      aAddr <= next_aAddr;
      hrdata <= next_hrdata;
      cfgStyle <= next_cfgStyle;
      cfgMaxb <= next_cfgMaxb;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Request shaping

  logic burstMode; // Either coalescing style
  logic nonal; // Misaligned elements allowed
  logic neverStall; // Waitrequest disregarded
  logic [CW-1:0] effMax; // Burst limit in force
  logic [OFFW-1:0] off; // Byte offset of the element
  logic [AW-1:0] wordAddr; // Word holding the first byte
  logic [2*DW-1:0] wideData; // Element placed over two words
  logic [2*BEW-1:0] wideBe; // Lanes placed over two words
  logic split; // Element spans two words
  logic oqRoom; // A further load may be tracked

  assign burstMode = (cfgStyle == STYLE_BURST) || (cfgStyle == STYLE_NONALIGNED);
  // misaligned handling only in this variant
  assign nonal = (cfgStyle == STYLE_NONALIGNED);
  assign neverStall = (cfgStyle == STYLE_NEVERSTALL);
  assign effMax = ((cfgMaxb == 8'h00) || (cfgMaxb > 8'(MAXB))) ? CW'(MAXB) : cfgMaxb[CW-1:0];
  assign off = nonal ? req.addr[OFFW-1:0] : '0;
  assign wordAddr = {req.addr[AW-1:OFFW], {OFFW{1'b0}}};
  // merged lanes travel as one word with byte enables
  assign wideData = {{DW{1'b0}}, req.data} << {off, 3'b000};
  assign wideBe = {{BEW{1'b0}}, req.be} << off;
  // spanning detected from lanes above the word
  assign split = nonal && (wideBe[2*BEW-1:BEW] != '0);
  assign oqRoom = (oqCnt < NW'(OQD));

  ////////////////////////////////////////////////////////////////////////////
  // Burst coalescing engine

  logic [DW-1:0] bufData [MAXB]; // Buffered write words
  logic [BEW-1:0] bufBe [MAXB]; // Buffered lanes
  logic [AW-1:0] bufAddr; // Address of the first buffered word
  logic bufWrite; // Buffer holds stores
  logic [IW-1:0] beat; // Current write beat
  logic secPend; // Second half of a spanning element
  logic secWrite;
  logic [AW-1:0] secAddr;
  logic [DW-1:0] secData;
  logic [BEW-1:0] secBe;
  lsu_state_e next_state;
  logic [CW-1:0] next_bufCnt;
  logic [AW-1:0] next_bufAddr;
  logic next_bufWrite;
  logic [IW-1:0] next_beat;
  logic next_secPend;
  logic next_secWrite;
  logic [AW-1:0] next_secAddr;
  logic [DW-1:0] next_secData;
  logic [BEW-1:0] next_secBe;
  logic bufWe; // Word enters the buffer
  logic [DW-1:0] bufWeData;
  logic [BEW-1:0] bufWeBe;
  logic srcValid; // Word offered to the buffer
  logic srcWrite;
  logic [AW-1:0] srcAddr;
  logic joinOk; // Offered word extends the burst
  logic burstReady; // Request taken by the engine
  logic burstOrdPush; // Load recorded by the engine

  // Collect, then flush as one command
  always_comb
  begin
    next_state = state;
    next_bufCnt = bufCnt;
    next_bufAddr = bufAddr;
    next_bufWrite = bufWrite;
    next_beat = beat;
    next_secPend = secPend;
    next_secWrite = secWrite;
    next_secAddr = secAddr;
    next_secData = secData;
    next_secBe = secBe;
    bufWe = 1'b0;
    bufWeData = '0;
    bufWeBe = '0;
    srcValid = 1'b0;
    srcWrite = 1'b0;
    srcAddr = '0;
    joinOk = 1'b0;
    burstReady = 1'b0;
    burstOrdPush = 1'b0;
    case (state)
      ST_COLLECT:
      begin
        // Pending upper half goes first
        if (secPend)
        begin
          srcValid = 1'b1;
          srcWrite = secWrite;
          srcAddr = secAddr;
          bufWeData = secData;
          bufWeBe = secBe;
        end
        else if (burstMode && reqValid && (req.write || oqRoom))
        begin
          srcValid = 1'b1;
          srcWrite = req.write;
          srcAddr = wordAddr;
          bufWeData = wideData[DW-1:0];
          bufWeBe = wideBe[BEW-1:0];
        end
        joinOk = (bufCnt == '0) || ((srcAddr == bufAddr + (AW'(bufCnt) << OFFW)) &&
          (srcWrite == bufWrite) && (bufCnt < effMax));
        if (srcValid && joinOk)
        begin
          bufWe = 1'b1;
          next_bufCnt = bufCnt + 1'b1;
          if (bufCnt == '0)
          begin
            next_bufAddr = srcAddr;
            next_bufWrite = srcWrite;
          end
          if (secPend)
            next_secPend = 1'b0;
          else
          begin
            burstReady = 1'b1;
            burstOrdPush = !req.write;
            // upper word queued for the same burst, or for the next one when the lower word fills it
            next_secPend = split;
            next_secWrite = req.write;
            next_secAddr = wordAddr + AW'(BEW);
            next_secData = wideData[2*DW-1:DW];
            next_secBe = wideBe[2*BEW-1:BEW];
          end
          if (bufCnt + 1'b1 == effMax)
            next_state = srcWrite ? ST_WRBURST : ST_RDBURST;
        end
        else if (bufCnt != '0)
          next_state = bufWrite ? ST_WRBURST : ST_RDBURST;
      end
      ST_WRBURST:
      begin
        if (!memWaitRequest)
        begin
          if (CW'(beat) == bufCnt - 1'b1)
          begin
            next_beat = '0;
            next_bufCnt = '0;
            next_state = ST_COLLECT;
          end
          else
            next_beat = beat + 1'b1;
        end
      end
      ST_RDBURST:
      begin
        if (!memWaitRequest)
        begin
          next_bufCnt = '0;
          next_state = ST_COLLECT;
        end
      end
      default: next_state = ST_COLLECT;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_COLLECT;
      bufCnt <= '0;
      bufAddr <= '0;
      bufWrite <= 1'b0;
      beat <= '0;
      secPend <= 1'b0;
      secWrite <= 1'b0;
      secAddr <= '0;
      secData <= '0;
      secBe <= '0;
    end
    else
    begin
      state <= next_state;
      bufCnt <= next_bufCnt;
      bufAddr <= next_bufAddr;
      bufWrite <= next_bufWrite;
      beat <= next_beat;
      secPend <= next_secPend;
      secWrite <= next_secWrite;
      secAddr <= next_secAddr;
      secData <= next_secData;
      secBe <= next_secBe;
    end
  end

  // Buffer storage, no reset needed
  always_ff @(posedge clock)
  begin
    if (bufWe)
    begin
      bufData[bufCnt[IW-1:0]] <= bufWeData;
      bufBe[bufCnt[IW-1:0]] <= bufWeBe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pipelined command slot

  lsu_mem_cmd_s pCmd; // Command in the slot
  logic next_pValid;
  lsu_mem_cmd_s next_pCmd;
  logic slotFree; // Slot can take a new command
  logic pipeReady; // Request taken by the slot

  // each request forwarded with no buffering
  always_comb
  begin
    slotFree = !pValid || !memWaitRequest || neverStall;
    pipeReady = !burstMode && slotFree && (req.write || oqRoom) && (state == ST_COLLECT) && (bufCnt == '0);
    next_pValid = slotFree ? 1'b0 : pValid;
    next_pCmd = pCmd;
    if (pipeReady && reqValid)
    begin
      next_pValid = 1'b1;
      next_pCmd.read = !req.write;
      next_pCmd.write = req.write;
      next_pCmd.addr = wordAddr;
      next_pCmd.burst = `LSU_BCW'(1);
      next_pCmd.wdata = req.data;
      next_pCmd.be = req.be;
    end
  end

  // Slot registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pValid <= 1'b0;
      pCmd <= '0;
    end
    else
    begin
      pValid <= next_pValid;
      pCmd <= next_pCmd;
    end
  end

  assign reqReady = burstReady || pipeReady;

  // Memory command from whichever path is active
  always_comb
  begin
    memCmd = '0;
    if (state == ST_WRBURST)
    begin
      memCmd.write = 1'b1;
      memCmd.addr = bufAddr;
      memCmd.burst = `LSU_BCW'(bufCnt);
      memCmd.wdata = bufData[beat];
      memCmd.be = bufBe[beat];
    end
    else if (state == ST_RDBURST)
    begin
      memCmd.read = 1'b1;
      memCmd.addr = bufAddr;
      memCmd.burst = `LSU_BCW'(bufCnt);
      memCmd.be = '1;
    end
    else if (pValid)
      memCmd = pCmd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load ordering and response assembly

  lsu_ord_s oq [OQD]; // Pending loads, oldest at oqRp
  logic [QW-1:0] oqWp;
  logic [QW-1:0] oqRp;
  logic haveLow; // Lower word of a spanning load held
  logic [DW-1:0] lowWord;
  logic [QW-1:0] next_oqWp;
  logic [QW-1:0] next_oqRp;
  logic [NW-1:0] next_oqCnt;
  logic next_haveLow;
  logic [DW-1:0] next_lowWord;
  logic [DW-1:0] next_rspData;
  logic next_rspValid;
  logic oqPush;
  logic oqPop;
  lsu_ord_s oqIn;
  lsu_ord_s head;
  logic [2*DW-1:0] joined;

  // data leaves in the order loads were taken
  always_comb
  begin
    // new loads accepted while others are in flight
    oqPush = burstOrdPush || (pipeReady && reqValid && !req.write);
    oqIn.split = burstOrdPush && split;
    oqIn.off = burstOrdPush ? 2'(off) : 2'b00;
    head = oq[oqRp];
    oqPop = 1'b0;
    next_haveLow = haveLow;
    next_lowWord = lowWord;
    next_rspData = rspData;
    next_rspValid = 1'b0;
    joined = head.split ? {memReadData, lowWord} : {{DW{1'b0}}, memReadData};
    if (memReadDataValid)
    begin
      if (head.split && !haveLow)
      begin
        next_haveLow = 1'b1;
        next_lowWord = memReadData;
      end
      else
      begin
        next_rspData = joined[{head.off, 3'b000} +: DW];
        next_rspValid = 1'b1;
        next_haveLow = 1'b0;
        oqPop = 1'b1;
      end
    end
    next_oqWp = oqPush ? QW'((oqWp == QW'(OQD - 1)) ? 0 : oqWp + 1'b1) : oqWp;
    next_oqRp = oqPop ? QW'((oqRp == QW'(OQD - 1)) ? 0 : oqRp + 1'b1) : oqRp;
    next_oqCnt = oqCnt + NW'(oqPush) - NW'(oqPop);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      oqWp <= '0;
      oqRp <= '0;
      oqCnt <= '0;
      haveLow <= 1'b0;
      lowWord <= '0;
      rspData <= '0;
      rspValid <= 1'b0;
    end
    else
    begin
      oqWp <= next_oqWp;
      oqRp <= next_oqRp;
      oqCnt <= next_oqCnt;
      haveLow <= next_haveLow;
      lowWord <= next_lowWord;
      rspData <= next_rspData;
      rspValid <= next_rspValid;
    end
  end

  // Order entries
  always_ff @(posedge clock)
  begin
    if (oqPush)
      oq[oqWp] <= oqIn;
  end

endmodule : lsu_mem_master_port

/* File: bench/lsu_port_asserts.sv */
// Port checker of the load-store unit
`timescale 1ns/100ps
module lsu_port_asserts
  import lsu_pkg::*;
#(
  parameter int MAXB = 8 // Deepest burst
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire lsu_req_s req,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire lsu_mem_cmd_s memCmd,
  input wire logic memWaitRequest,
  input wire logic memReadDataValid
);
  logic wrPend; // Register write in data phase
  logic [31:0] wrAddr; // Its address
  logic [31:0] ctrl; // Shadow of control register
  logic cmd; // Command on the port
  int lim; // Burst length in force
  assign cmd = memCmd.read | memCmd.write;
  assign lim = (ctrl[15:8] == 8'h00 || int'(ctrl[15:8]) > MAXB) ? MAXB : int'(ctrl[15:8]);
  ////////////////////////////////////////////////////////////////
  // Follow control writes
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wrPend <= 1'b0;
      wrAddr <= 32'h0;
      ctrl <= 32'h0;
    end
    else
    begin
      wrPend <= hsel & htrans[1] & hready & hwrite;
      wrAddr <= haddr;
      if (wrPend && wrAddr == 32'h0)
        ctrl <= hwdata;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence pipeTake;
    reqValid && reqReady && ctrl[1];
  endsequence
  sequence stalled;
    cmd && memWaitRequest && ctrl[1:0] != 2'h3;
  endsequence
  reset_quiet_a: assert property ($fell(rst) |-> !cmd && !rspValid)
    else $error("Activity right after reset");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("Register bus not ready or not okay");
  burst_bound_a: assert property (cmd |-> memCmd.burst != 8'h00 && int'(memCmd.burst) <= lim)
    else $error("Burst length out of bounds");
  word_align_a: assert property (cmd |-> memCmd.addr[1:0] == 2'h0)
    else $error("Access wider than port word");
  pipe_single_a: assert property (cmd && ctrl[1] |-> memCmd.burst == 8'h01)
    else $error("Pipelined command forms a burst");
  wait_hold_a: assert property (stalled |=> $stable(memCmd))
    else $error("Command changed while stalled");
  pipe_forward_a: assert property (pipeTake |=> cmd && memCmd.write == $past(req.write)
    && memCmd.addr == {$past(req.addr[31:2]), 2'h0})
    else $error("Pipelined request not forwarded");
  nstall_drop_a: assert property (ctrl[1:0] == 2'h3 && cmd && !(reqValid && reqReady) |=> !cmd)
    else $error("Never-stall command held over");
  rsp_beat_a: assert property (rspValid |-> $past(memReadDataValid))
    else $error("Load returned without a beat");
  pipe_b2b_c: cover property (pipeTake ##1 pipeTake);
endmodule : lsu_port_asserts

/* File: bench/lsu_mem_model.sv */
// Behavioural memory slave at the far side
`timescale 1ns/100ps
module lsu_mem_model
  import lsu_pkg::*;
#(
  parameter int LAT = 2 // Read latency in cycles
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic slow,
  input wire lsu_mem_cmd_s memCmd,
  output logic memWaitRequest,
  output logic memReadDataValid,
  output logic [31:0] memReadData
);
  logic [31:0] mem [0:1023]; // Word store
  logic [31:0] dataQ[$]; // Beats waiting
  int dueQ[$]; // Cycle each beat is due
  int cyc; // Cycle count
  int beat; // Write beat in burst
  int idx; // Word written
  logic stallTog; // Alternating stall
  assign memWaitRequest = slow & stallTog;
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dataQ.delete();
      dueQ.delete();
      cyc = 0;
      beat = 0;
      stallTog <= 1'b0;
      memReadDataValid <= 1'b0;
      memReadData <= 32'h0;
    end
    else
    begin
      cyc++;
      stallTog <= ~stallTog;
      memReadDataValid <= 1'b0;
      // Idle data changes every cycle
      memReadData <= ~memReadData;
      if (dueQ.size() != 0 && dueQ[0] <= cyc)
      begin
        void'(dueQ.pop_front());
        memReadDataValid <= 1'b1;
        memReadData <= dataQ.pop_front();
      end
      if (!memWaitRequest && memCmd.read)
        for (int k = 0; k < int'(memCmd.burst); k++)
        begin
          dataQ.push_back(mem[int'(memCmd.addr[11:2]) + k]);
          dueQ.push_back(cyc + LAT - 1 + k + (slow ? 3 : 0));
        end
      if (!memWaitRequest && memCmd.write)
      begin
        idx = int'(memCmd.addr[11:2]) + beat;
        for (int b = 0; b < 4; b++)
          if (memCmd.be[b])
            mem[idx][8*b+:8] = memCmd.wdata[8*b+:8];
        beat = (beat + 1 == int'(memCmd.burst)) ? 0 : beat + 1;
      end
    end
  end
endmodule : lsu_mem_model

/* File: bench/testbench.sv */
// Self-checking bench of the load-store unit
`timescale 1ns/100ps
module testbench;
  import lsu_pkg::*;
  logic clock, rst, hsel, hwrite, slow, reqValid, hreadyout, hresp, reqReady, rspValid;
  logic memWaitRequest, memReadDataValid;
  logic [31:0] haddr, hwdata, hrdata, rspData, memReadData, rd, base;
  logic [1:0] htrans;
  logic [2:0] hsize;
  lsu_req_s req;
  lsu_mem_cmd_s memCmd;
  wire hready = hreadyout; // Single slave drives ready
  logic [31:0] expQ[$]; // Loads awaiting data
  int err_count, num_checks;
  lsu_mem_master_port u_dut (.*);
  lsu_mem_model u_mem (.*);
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One register transfer
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // One datapath request, held until taken
  task send(input logic w, input logic [31:0] a, input logic [31:0] d);
    bit ok;
    req <= '{write: w, addr: a, data: d, be: 4'hf};
    reqValid <= 1'b1;
    do
    begin
      @(negedge clock);
      ok = (reqReady === 1'b1);
      @(posedge clock);
    end
    while (!ok);
    if (!w)
      expQ.push_back(d);
  endtask : send
  // Drop valid, poll status until idle
  task idle_wait;
    int n;
    n = 0;
    reqValid <= 1'b0;
    do ahb(1'b0, 32'h4, 32'h0);
    while ((rd[0] !== 1'b0 || rd[23:8] !== 16'h0 || expQ.size() != 0) && ++n < 200);
    // Unit stuck busy counts as a failure
    if (n >= 200)
    begin
      err_count++;
      $display("ERROR %0t unit never went idle", $time);
      close_out();
    end
  endtask : idle_wait
  function automatic logic [31:0] adr(input int i);
    return base + ((i == 4) ? 32'h20 : 32'(4 * i));
  endfunction : adr
  function automatic logic [31:0] pat(input int s, input int i);
    return {8'h5a, 8'(s), 8'(i), 8'(~i)};
  endfunction : pat
  task close_out;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////
  // Load data checked in arrival order
  always @(negedge clock)
    if (rspValid === 1'b1)
    begin
      // Load data with nothing pending is always wrong
      if (expQ.size() == 0)
      begin
        err_count++;
        $display("ERROR %0t load data with no load pending", $time);
      end
      else
        chk(rspData, expQ.pop_front());
    end
  initial
  begin
    #(50 * 20000);
    err_count++;
    $display("ERROR %0t watchdog expired", $time);
    close_out();
  end
  initial
  begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    slow = 1'b0;
    reqValid = 1'b0;
    req = '0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, 32'h8, 32'hffff_ffff);
    ahb(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    for (int s = 0; s < 4; s++)
    begin
      ahb(1'b1, 32'h0, {16'h0, (s == 0) ? 8'h02 : 8'h00, 6'h0, 2'(s)});
      ahb(1'b0, 32'h0, 32'h0);
      chk(rd, {16'h0, (s == 0) ? 8'h02 : 8'h00, 6'h0, 2'(s)});
      slow <= (s == 0 || s == 2);
      base = 32'h400 + 32'(s * 64) + ((s == 1) ? 32'h2 : 32'h0);
      // Contiguous stores then a distant one
      for (int i = 0; i < 5; i++)
        send(1'b1, adr(i), pat(s, i));
      idle_wait();
      if (s != 1)
        for (int i = 0; i < 5; i++)
          chk(u_mem.mem[adr(i) >> 2], pat(s, i));
      // Back-to-back loads
      for (int i = 0; i < 5; i++)
        send(1'b0, adr(i), pat(s, i));
      idle_wait();
      chk(32'(expQ.size()), 32'h0);
      $display("test style %0d done", s);
    end
    // Second reset in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    $display("test second reset done");
    close_out();
  end
endmodule : testbench
bind lsu_mem_master_port lsu_port_asserts #(.MAXB(MAXB)) u_chk (.*);
